/* File: rtl/aefb_top.sv */
// almost-empty flag bus control with start-up straps and register slave
//
// Contract
// - bus-match, input and output width straps set port widths, held steady
// - default programming: latched offset strap gives offsets 8 when low, 128 high
// - default-programming strap at master reset: low serial, high default
// - after each master reset, programming completes before queue operation
// - direct mode: addressed device takes bus on edge with strobe high; here the strobe pin passes two sync flops, so ownership starts two edges later
// - polled: each device loads its status onto the bus in turn
// - polled: sync output high during the cycle this device's status is on bus
// - token input comes from token output of preceding chain device
// - flag-mode strap at master reset: high polled, low direct
// - token output pulses while status on bus; next device loads next edge; here token_in passes two sync flops, so loading comes two edges later
// - packet mode puts packet-ready status on the almost-empty bus
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module aefb_top
	import aefb_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_b_in,
	input  wire logic [31:0]           haddr_in,
	input  wire logic                  hsel_in,
	input  wire logic [1:0]            htrans_in,
	input  wire logic                  hwrite_in,
	input  wire logic [2:0]            hsize_in,
	input  wire logic [31:0]           hwdata_in,
	input  wire logic                  hready_in,
	output logic      [31:0]           hrdata_out,
	output logic                       hreadyout_out,
	output logic                       hresp_out,
	input  wire logic                  master_reset_b_in,
	input  wire logic                  bus_match_select_in,
	input  wire logic                  input_width_select_in,
	input  wire logic                  output_width_select_in,
	input  wire logic                  default_offset_select_in,
	input  wire logic                  default_programming_select_in,
	input  wire logic                  flag_bus_mode_select_in,
	input  wire logic                  empty_bus_strobe_in,
	input  wire logic [DEV_ADDR_W-1:0] read_queue_address_in,
	input  wire logic                  token_in,
	input  wire logic [QUEUES-1:0]     queue_almost_empty_in,
	input  wire logic [QUEUES-1:0]     queue_packet_ready_in,
	output logic      [QUEUES-1:0]     almost_empty_bus_out,
	output logic                       almost_empty_bus_oe_out,
	output logic                       empty_bus_sync_out,
	output logic                       token_out,
	output logic                       serial_enable_out,
	output logic                       queue_ready_out,
	output logic      [2:0]            width_config_out,
	output logic      [OFS_W-1:0]      flag_offset_out,
	output logic                       polled_mode_out,
	output logic                       irq_out
);

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	localparam int PIN_W = STRAP_W + 3 + DEV_ADDR_W;

	logic [PIN_W-1:0]      pins_s;
	logic [STRAP_W-1:0]    strap_s;
	logic                  mrs_b_s;
	logic                  strobe_s;
	logic                  tok_s;
	logic [DEV_ADDR_W-1:0] raddr_s;

	aefb_sync2 #(
		.W (PIN_W)
	) u_sync (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.d_in       ({read_queue_address_in, token_in, empty_bus_strobe_in, master_reset_b_in,
		              flag_bus_mode_select_in, default_programming_select_in, default_offset_select_in,
		              output_width_select_in, input_width_select_in, bus_match_select_in}),
		.q_out      (pins_s)
	);

	assign strap_s  = pins_s[STRAP_W-1:0];
	assign mrs_b_s  = pins_s[STRAP_W];
	assign strobe_s = pins_s[STRAP_W+1];
	assign tok_s    = pins_s[STRAP_W+2];
	assign raddr_s  = pins_s[PIN_W-1 -: DEV_ADDR_W];

	// -----------------------------------------------------------------
	// strap capture
	// -----------------------------------------------------------------
	logic [STRAP_W-1:0] strap_q;

	// straps follow the pins while master reset is held, frozen after release
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			strap_q <= '0;
		else if (!mrs_b_s)
			strap_q <= strap_s;
	end

	// -----------------------------------------------------------------
	// register bus slave
	// -----------------------------------------------------------------
	logic [31:0]       ctrl_q;
	logic [OFS_W-1:0]  sofs_q;
	logic [31:0]       hrdata_q;
	logic              dph_we_q;
	logic [7:0]        dph_addr_q;
	logic              aph_take;
	logic [IRQ_N-1:0]  irq_stat;
	logic [IRQ_N-1:0]  irq_en;
	logic [IRQ_N-1:0]  irq_ev;
	logic              wr_clr;
	logic              wr_en;
	logic              own_q;
	logic              sen_q;
	aefb_state_t       state_q;
	aefb_state_t       state_d;

	function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
		reg_hit = (a[31:8] == 24'h00_0000) && (a[7:2] == off[7:2]);
	endfunction

	function automatic logic [31:0] reg_read(input logic [31:0] a);
		reg_read = 32'h0000_0000;
		if (reg_hit(a, REG_CTRL))
			reg_read = ctrl_q;
		if (reg_hit(a, REG_STATUS))
			reg_read = {21'h00_0000, sen_q, own_q, (state_q == ST_RUN), 2'h0, strap_q};
		if (reg_hit(a, REG_IRQ_STAT))
			reg_read = {{(32-IRQ_N){1'b0}}, irq_stat};
		if (reg_hit(a, REG_IRQ_EN))
			reg_read = {{(32-IRQ_N){1'b0}}, irq_en};
		if (reg_hit(a, REG_SER_OFS))
			reg_read = {{(32-OFS_W){1'b0}}, sofs_q};
	endfunction

	assign aph_take = hsel_in && hready_in && htrans_in[1] && (hsize_in == 3'b010);

	// zero wait states; read data is fetched at the address phase
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			dph_we_q   <= 1'b0;
			dph_addr_q <= 8'h00;
			hrdata_q   <= 32'h0000_0000;
		end
		else
		begin
			dph_we_q <= aph_take && hwrite_in;
			if (aph_take)
			begin
				dph_addr_q <= haddr_in[31:8] == 24'h00_0000 ? haddr_in[7:0] : 8'hFC;
				hrdata_q   <= hwrite_in ? 32'h0000_0000 : reg_read(haddr_in);
			end
		end
	end

	// serial-done flag drops at every master reset so serial-mode reprogramming is forced
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ctrl_q <= CTRL_RST;
		else if (!mrs_b_s)
			ctrl_q[CTRL_SER_DONE] <= 1'b0;
		else if (dph_we_q && reg_hit({24'h00_0000, dph_addr_q}, REG_CTRL))
			ctrl_q <= {25'h000_0000, hwdata_in[CTRL_ADDR_LSB +: DEV_ADDR_W], 1'b0, hwdata_in[2:0]};
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			sofs_q <= SOFS_RST;
		else if (dph_we_q && reg_hit({24'h00_0000, dph_addr_q}, REG_SER_OFS))
			sofs_q <= hwdata_in[OFS_W-1:0];
	end

	assign wr_clr = dph_we_q && reg_hit({24'h00_0000, dph_addr_q}, REG_IRQ_CLR);
	assign wr_en  = dph_we_q && reg_hit({24'h00_0000, dph_addr_q}, REG_IRQ_EN);

	assign hrdata_out    = hrdata_q;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// -----------------------------------------------------------------
	// programming state
	// -----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		if (!mrs_b_s)
			state_d = ST_MRST;
		else
		begin
			unique case (state_q)
				ST_MRST: state_d = ST_PROG;
				ST_PROG: if (strap_q[SP_DFM] || ctrl_q[CTRL_SER_DONE])
						state_d = ST_RUN;
				ST_RUN:  state_d = ST_RUN;
				default: state_d = ST_MRST;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_q <= ST_MRST;
			sen_q   <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			sen_q   <= state_d != ST_RUN;
		end
	end

	// -----------------------------------------------------------------
	// flag bus ownership
	// -----------------------------------------------------------------
	logic              run;
	logic              polled;
	logic              start_q;
	logic              own_d;
	logic              addr_match;
	logic [QUEUES-1:0] bus_q;
	logic [OFS_W-1:0]  ofs_q;

	assign run        = state_q == ST_RUN;
	assign polled     = strap_q[SP_FM];
	assign addr_match = raddr_s == ctrl_q[CTRL_ADDR_LSB +: DEV_ADDR_W];

	// the first device of a polled chain launches the token once
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			start_q <= 1'b0;
		else
			start_q <= !run && state_d == ST_RUN && ctrl_q[CTRL_FIRST] && polled;
	end

	always_comb
	begin
		own_d = own_q;
		if (!run)
			own_d = 1'b0;
		else if (polled)
			own_d = tok_s || start_q;
		else if (strobe_s)
			own_d = addr_match;
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			own_q <= 1'b0;
		else
			own_q <= own_d;
	end

	// status is loaded on every edge at which ownership is granted or held
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			bus_q <= '0;
		else if (own_d)
			bus_q <= ctrl_q[CTRL_PKT_MODE] ? queue_packet_ready_in : queue_almost_empty_in;
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ofs_q <= OFS_LOW;
		else if (strap_q[SP_DFM])
			ofs_q <= strap_q[SP_DF] ? OFS_HIGH : OFS_LOW;
		else
			ofs_q <= sofs_q;
	end

	assign almost_empty_bus_out    = bus_q;
	assign almost_empty_bus_oe_out = own_q;
	assign empty_bus_sync_out      = own_q && polled;
	assign token_out               = own_q && polled;
	assign serial_enable_out       = sen_q;
	assign queue_ready_out         = run;
	assign width_config_out        = {strap_q[SP_OW], strap_q[SP_IW], strap_q[SP_BM]};
	assign flag_offset_out         = ofs_q;
	assign polled_mode_out         = polled;

	// -----------------------------------------------------------------
	// interrupts
	// -----------------------------------------------------------------
	// early strobe flags a controller that strobes before programming ends
	assign irq_ev[IRQ_PROG]  = !run && state_d == ST_RUN;
	assign irq_ev[IRQ_TOKEN] = run && polled && tok_s;
	assign irq_ev[IRQ_TAKE]  = own_d && !own_q && !polled;
	assign irq_ev[IRQ_EARLY] = strobe_s && !run;

	aefb_irq #(
		.N (IRQ_N)
	) u_irq (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.ev_in      (irq_ev),
		.clr_we_in  (wr_clr),
		.en_we_in   (wr_en),
		.wdata_in   (hwdata_in[IRQ_N-1:0]),
		.status_out (irq_stat),
		.enable_out (irq_en),
		.irq_out    (irq_out)
	);

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_strap_frozen: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		mrs_b_s && $past(mrs_b_s) |-> $stable(strap_q))
		else $error("straps changed outside master reset");

	a_default_ofs: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		run && strap_q[SP_DFM] && $past(run) |-> flag_offset_out == (strap_q[SP_DF] ? 8'h80 : 8'h08))
		else $error("default offset wrong");

	a_default_prog: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		state_q == ST_PROG && strap_q[SP_DFM] && mrs_b_s |=> run ##1 !serial_enable_out)
		else $error("default programming did not finish");

	a_no_own_unprog: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		!run |=> !almost_empty_bus_oe_out)
		else $error("bus driven before programming");

	a_direct_take: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		run && !polled && strobe_s && mrs_b_s |=> almost_empty_bus_oe_out == $past(addr_match))
		else $error("direct selection wrong");

	a_poll_load: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		run && polled && tok_s && mrs_b_s |=> almost_empty_bus_oe_out && bus_q == $past(ctrl_q[CTRL_PKT_MODE]
			? queue_packet_ready_in : queue_almost_empty_in))
		else $error("polled load missed");

	a_sync_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		run && polled && mrs_b_s && (tok_s || start_q) |=> empty_bus_sync_out && almost_empty_bus_oe_out)
		else $error("sync missing while status on bus");

	a_token_single: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		token_out && !tok_s && !start_q |=> !token_out)
		else $error("token pulse too long");

	a_release: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		run && !polled && strobe_s && !addr_match && mrs_b_s |=> !almost_empty_bus_oe_out)
		else $error("bus not released");

endmodule
`default_nettype wire

/* File: rtl/aefb_pkg.sv */
// constants for the almost-empty flag bus control block
package aefb_pkg;

	// -----------------------------------------------------------------
	// register byte offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h0C;
	localparam logic [7:0] REG_IRQ_EN   = 8'h10;
	localparam logic [7:0] REG_SER_OFS  = 8'h14;

	// -----------------------------------------------------------------
	// field positions and widths
	// -----------------------------------------------------------------
	localparam int CTRL_SER_DONE = 0;
	localparam int CTRL_PKT_MODE = 1;
	localparam int CTRL_FIRST    = 2;
	localparam int CTRL_ADDR_LSB = 4;
	localparam int DEV_ADDR_W    = 3;
	localparam int QUEUES        = 4;
	localparam int OFS_W         = 8;
	localparam int STRAP_W       = 6;

	// status register fields
	localparam int ST_STRAP_LSB = 0;
	localparam int ST_RUN_BIT   = 8;
	localparam int ST_OWN_BIT   = 9;
	localparam int ST_SEN_BIT   = 10;

	// strap vector bit order
	localparam int SP_BM  = 0;
	localparam int SP_IW  = 1;
	localparam int SP_OW  = 2;
	localparam int SP_DF  = 3;
	localparam int SP_DFM = 4;
	localparam int SP_FM  = 5;

	// interrupt bits
	localparam int IRQ_PROG  = 0;
	localparam int IRQ_TOKEN = 1;
	localparam int IRQ_TAKE  = 2;
	localparam int IRQ_EARLY = 3;
	localparam int IRQ_N     = 4;

	// -----------------------------------------------------------------
	// reset and default values
	// -----------------------------------------------------------------
	localparam logic [OFS_W-1:0] OFS_LOW   = 8'h08;
	localparam logic [OFS_W-1:0] OFS_HIGH  = 8'h80;
	localparam logic [31:0]      CTRL_RST  = 32'h0000_0000;
	localparam logic [OFS_W-1:0] SOFS_RST  = 8'h08;

	typedef enum logic [1:0]
	{
		ST_MRST = 2'b00,
		ST_PROG = 2'b01,
		ST_RUN  = 2'b10
	} aefb_state_t;

endpackage

/* File: rtl/aefb_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module aefb_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_b_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage is read by the second stage only
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end

	assign q_out = sync_q;
endmodule
`default_nettype wire

/* File: rtl/aefb_irq.sv */
// sticky interrupt status, enable and level interrupt output
`timescale 1ns/10ps
`default_nettype none
module aefb_irq #(
	parameter int N = 4
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_b_in,
	input  wire logic [N-1:0] ev_in,
	input  wire logic         clr_we_in,
	input  wire logic         en_we_in,
	input  wire logic [N-1:0] wdata_in,
	output logic      [N-1:0] status_out,
	output logic      [N-1:0] enable_out,
	output logic              irq_out
);
	logic [N-1:0] stat_q;
	logic [N-1:0] en_q;
	logic         irq_q;

	// a new event beats a clear in the same cycle
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			stat_q <= '0;
		else
			stat_q <= (stat_q & ~(clr_we_in ? wdata_in : '0)) | ev_in;
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			en_q <= '0;
		else if (en_we_in)
			en_q <= wdata_in;
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			irq_q <= 1'b0;
		else
			irq_q <= |(((stat_q & ~(clr_we_in ? wdata_in : '0)) | ev_in) & (en_we_in ? wdata_in : en_q));
	end

	assign status_out = stat_q;
	assign enable_out = en_q;
	assign irq_out    = irq_q;
endmodule
`default_nettype wire

/* File: verif/aefb_peer.sv */
// far-side model: flow controller and lone chain neighbour
`timescale 1ns/10ps
`default_nettype none
module aefb_peer (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	input  wire logic       loop_in,
	input  wire logic       req_in,
	input  wire logic       early_in,
	input  wire logic [2:0] addr_in,
	input  wire logic       polled_in,
	input  wire logic       sen_in,
	input  wire logic       token_back_in,
	output logic            token_out,
	output logic            strobe_out,
	output logic      [2:0] addr_out
);
	// ----------------------------------------
	// token wiring
	// ----------------------------------------
	// lone device: loop back only in polled mode, low in direct mode
	assign token_out = loop_in & polled_in & token_back_in;

	// ----------------------------------------
	// strobe and address
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			strobe_out <= 1'b0;
			addr_out   <= 3'h0;
		end
		else
		begin
			// early_in breaks the start-up order on purpose
			strobe_out <= req_in & ~polled_in & (early_in | ~sen_in);
			// address is not held outside a strobe: keep it moving
			addr_out   <= req_in ? addr_in : ~addr_out;
		end
	end
endmodule
`default_nettype wire

/* File: verif/aefb_top_tb.sv */
// self-checking testbench for the flag bus control block
`timescale 1ns/10ps
`default_nettype none
module aefb_top_tb
	import aefb_pkg::*;
;
	logic        clk_sys, rst_b, hsel, hwrite, hready, mrst_b, strobe, tok, loop, req, early;
	logic        polled, sen, tok_o, sync, oe, qrdy, irq, hrdy_o, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize, raddr, paddr, wcfg;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [5:0]  straps;
	logic [3:0]  bus, ae_wire;
	logic [3:0]  qae = 4'hA;
	logic [3:0]  qpr = 4'h5;
	logic [7:0]  ofs;
	int          mismatches, n_tests, cnt;

	// released bus lines float up through the pull-up
	assign ae_wire = oe ? bus : 4'hF;

	always #5 clk_sys = ~clk_sys;

	// the one slave's hreadyout is the bus's hready
	assign hready = hrdy_o;

	aefb_top dut (
		.clk_sys_in(clk_sys), .rst_b_in(rst_b), .haddr_in(haddr), .hsel_in(hsel),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hrdy_o), .hresp_out(hresp),
		.master_reset_b_in(mrst_b), .bus_match_select_in(straps[SP_BM]),
		.input_width_select_in(straps[SP_IW]), .output_width_select_in(straps[SP_OW]),
		.default_offset_select_in(straps[SP_DF]), .default_programming_select_in(straps[SP_DFM]),
		.flag_bus_mode_select_in(straps[SP_FM]), .empty_bus_strobe_in(strobe),
		.read_queue_address_in(raddr), .token_in(tok), .queue_almost_empty_in(qae),
		.queue_packet_ready_in(qpr), .almost_empty_bus_out(bus), .almost_empty_bus_oe_out(oe),
		.empty_bus_sync_out(sync), .token_out(tok_o), .serial_enable_out(sen),
		.queue_ready_out(qrdy), .width_config_out(wcfg), .flag_offset_out(ofs),
		.polled_mode_out(polled), .irq_out(irq)
	);

	aefb_peer peer (
		.clk_sys_in(clk_sys), .rst_b_in(rst_b), .loop_in(loop), .req_in(req), .early_in(early),
		.addr_in(paddr), .polled_in(polled), .sen_in(sen), .token_back_in(tok_o),
		.token_out(tok), .strobe_out(strobe), .addr_out(raddr)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_of_test();
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one single-word transfer; address phase held until hready is seen
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {24'h000000, a};
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask

	task automatic mreset(input logic [5:0] s);
		@(posedge clk_sys);
		straps <= s;
		mrst_b <= 1'b0;
		repeat (4) @(posedge clk_sys);
		mrst_b <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask

	// strobe one address, then wait for the expected ownership
	task automatic select(input logic [2:0] a, input logic v);
		@(posedge clk_sys);
		req   <= 1'b1;
		paddr <= a;
		@(posedge clk_sys);
		req <= 1'b0;
		cnt = 0;
		while (oe !== v && cnt < 10)
		begin
			@(posedge clk_sys);
			cnt++;
		end
		@(negedge clk_sys);
		chk(oe, v);
	endtask

	// sync pulses over 30 cycles; token and bus checked at each pulse
	task automatic count_sync();
		cnt = 0;
		repeat (30)
		begin
			@(negedge clk_sys);
			chk({tok_o, sync}, {oe, oe});
			if (sync === 1'b1)
			begin
				cnt++;
				chk(ae_wire, qae);
			end
		end
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		{clk_sys, rst_b, hsel, hwrite, loop, req, early} = 7'h00;
		{htrans, haddr, hwdata, paddr} = '0;
		hsize  = 3'b010;
		mrst_b = 1'b1;
		straps = 6'h00;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(negedge clk_sys);
		chk({hrdy_o, hresp, sen, qrdy, ofs}, {4'b1010, OFS_LOW});
		rdchk(REG_SER_OFS, 32'h00000008);
		rdchk(8'h40, 32'h00000000);
		for (int d = 0; d < 2; d++)
		begin
			mreset({2'b01, d[0], 3'b101});
			chk(ofs, d ? OFS_HIGH : OFS_LOW);
			chk({wcfg, polled, sen, qrdy}, 6'b101001);
			rdchk(REG_STATUS, {21'h0, 3'b001, 2'b00, 2'b01, d[0], 3'b101});
		end
		mreset(6'b001010);
		chk({sen, qrdy}, 2'b10);
		early <= 1'b1;
		select(3'h5, 1'b0);
		early <= 1'b0;
		ahb(1'b1, REG_SER_OFS, 32'h00000033);
		ahb(1'b1, REG_CTRL, 32'h00000051);
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({sen, qrdy, ofs}, {2'b01, 8'h33});
		select(3'h5, 1'b1);
		chk(ae_wire, qae);
		select(3'h3, 1'b0);
		chk(ae_wire, 4'hF);
		ahb(1'b1, REG_CTRL, 32'h00000053);
		select(3'h5, 1'b1);
		chk(ae_wire, qpr);
		// owned bus follows the queue status on every cycle
		@(posedge clk_sys);
		qpr <= 4'h9;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(ae_wire, 4'h9);
		rdchk(REG_IRQ_STAT, 32'h0000000D);
		ahb(1'b1, REG_IRQ_EN, 32'h00000004);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(irq, 1'b1);
		ahb(1'b1, REG_IRQ_CLR, 32'h0000000F);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(irq, 1'b0);
		rdchk(REG_IRQ_STAT, 32'h00000000);
		ahb(1'b1, REG_CTRL, 32'h00000004);
		loop <= 1'b1;
		mreset(6'b110101);
		count_sync();
		chk(cnt, 10);
		ahb(1'b0, REG_IRQ_STAT, 32'h00000000);
		chk(rd[IRQ_TOKEN], 1'b1);
		loop <= 1'b0;
		repeat (10) @(posedge clk_sys);
		count_sync();
		chk(cnt, 0);
		end_of_test();
	end

	// the sequence needs about 230 cycles; give it ample room
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
